// *** design/pin_remap_pkg.sv ***
// package: register map, field layout and reset values of the input remap selectors
package pin_remap_pkg;
   localparam int unsigned ADDR_W        = 12;
   localparam int unsigned DATA_W        = 32;
   localparam int unsigned SEL_W         = 5;
   localparam int unsigned PIN_COUNT     = 26;
   localparam int unsigned REG_COUNT     = 7;
   localparam int unsigned FIELD_COUNT   = 10;
   // printed offsets absent: byte addresses chosen for this block
   localparam logic [ADDR_W-1:0] CAPTURE_SEVEN_EIGHT_PIN_SELECT_ADDR = 12'h000;
   localparam logic [ADDR_W-1:0] COMPARE_FAULT_PIN_SELECT_ADDR       = 12'h004;
   localparam logic [ADDR_W-1:0] PWM_ONE_FAULT_PIN_SELECT_ADDR       = 12'h008;
   localparam logic [ADDR_W-1:0] PWM_TWO_FAULT_PIN_SELECT_ADDR       = 12'h00c;
   localparam logic [ADDR_W-1:0] ENCODER_ONE_PHASE_PIN_SELECT_ADDR   = 12'h010;
   localparam logic [ADDR_W-1:0] ENCODER_ONE_INDEX_PIN_SELECT_ADDR   = 12'h014;
   localparam logic [ADDR_W-1:0] ENCODER_TWO_PHASE_PIN_SELECT_ADDR   = 12'h018;
   localparam logic [ADDR_W-1:0] LOCK_CONTROL_ADDR                   = 12'h01c;
   localparam int unsigned LOW_FIELD_LSB  = 0;
   localparam int unsigned HIGH_FIELD_LSB = 8;
   localparam int unsigned LOCK_BIT       = 0;
   localparam logic [SEL_W-1:0] SEL_RESET  = 5'h1f;
   localparam logic [SEL_W-1:0] SEL_MAX_PIN = 5'h19;
   localparam logic               LOCK_RESET = 1'b0;
endpackage : pin_remap_pkg

// *** design/input_pin_remap_select.sv ***
// input remap selectors with apb register access
// Summary of operation
// [R1] each 5-bit field routes the pin whose index equals its value, 0 to 25
// [R2] all-ones code ties the peripheral input low
// [R3] every select bit resets to one, so all inputs start tied low
// [R4] unimplemented bits read zero and ignore writes
// [R5] register one: bits 12:8 capture eight, bits 4:0 capture seven
// [R6] register two: bits 4:0 compare fault a, upper bits unimplemented
// [R7] register three: bits 4:0 first pwm fault input
// [R8] register four: bits 4:0 second pwm fault input
// [R9] register five: bits 12:8 encoder one phase b, bits 4:0 phase a
// [R10] register six: bits 4:0 encoder one index
// [R11] register seven: bits 12:8 encoder two phase b, bits 4:0 phase a
// [R12] select fields are read/write and read back the last value written
// [R13] selector writes are ignored while the write lock bit is set
// [R14] routing is registered, one clock behind the pins; codes 26 to 30 also tie the input low
`timescale 1ns/1ns
module input_pin_remap_select
   import pin_remap_pkg::*;
(
   input  wire logic                             mclk,
   input  wire logic                             rst_b,
   input  wire logic                             psel,
   input  wire logic                             penable,
   input  wire logic                             pwrite,
   input  wire logic [pin_remap_pkg::ADDR_W-1:0] paddr,
   input  wire logic [pin_remap_pkg::DATA_W-1:0] pwdata,
   input  wire logic [3:0]                       pstrb,
   output logic      [pin_remap_pkg::DATA_W-1:0] prdata,
   output logic                                  pready,
   output logic                                  pslverr,
   input  wire logic [pin_remap_pkg::PIN_COUNT-1:0] remappable_pin_n,
   output logic                                  capture_channel_seven_input,
   output logic                                  capture_channel_eight_input,
   output logic                                  compare_fault_a_input,
   output logic                                  pwm_one_fault_input,
   output logic                                  pwm_two_fault_input,
   output logic                                  encoder_one_phase_a,
   output logic                                  encoder_one_phase_b,
   output logic                                  encoder_one_index,
   output logic                                  encoder_two_phase_a,
   output logic                                  encoder_two_phase_b,
   output logic                                  pin_select_write_lock
);
   import pin_remap_pkg::*;

   typedef struct packed {
      logic [SEL_W-1:0] capture_seven_pin_field;
      logic [SEL_W-1:0] capture_eight_pin_field;
      logic [SEL_W-1:0] compare_fault_pin_field;
      logic [SEL_W-1:0] pwm_one_fault_pin_field;
      logic [SEL_W-1:0] pwm_two_fault_pin_field;
      logic [SEL_W-1:0] encoder_one_phase_a_pin_field;
      logic [SEL_W-1:0] encoder_one_phase_b_pin_field;
      logic [SEL_W-1:0] encoder_one_index_pin_field;
      logic [SEL_W-1:0] encoder_two_phase_a_pin_field;
      logic [SEL_W-1:0] encoder_two_phase_b_pin_field;
      logic             lock;
      logic [DATA_W-1:0] rdata;
      logic              slverr;
      logic [FIELD_COUNT-1:0] routed;
   } state_t;

   state_t state_ff;
   state_t nxt_state;

   // pin pick; out-of-range codes including all-ones give ground
   function automatic logic route_pin(input logic [SEL_W-1:0] sel,
                                      input logic [PIN_COUNT-1:0] pins);
      logic lvl;
      lvl = 1'b0;
      if (sel <= SEL_MAX_PIN) // [R1] [R14]
      begin
         lvl = pins[sel];
      end
      return lvl; // [R2]
   endfunction : route_pin

   // place two fields into a read word; bits outside them are zero
   function automatic logic [DATA_W-1:0] pack_pair(input logic [SEL_W-1:0] hi,
                                                   input logic [SEL_W-1:0] lo);
      logic [DATA_W-1:0] w;
      w = '0;
      w[HIGH_FIELD_LSB +: SEL_W] = hi;
      w[LOW_FIELD_LSB +: SEL_W]  = lo;
      return w; // [R4]
   endfunction : pack_pair

   function automatic logic [DATA_W-1:0] pack_one(input logic [SEL_W-1:0] lo);
      logic [DATA_W-1:0] w;
      w = '0;
      w[LOW_FIELD_LSB +: SEL_W] = lo;
      return w; // [R4]
   endfunction : pack_one

   logic setup_phase;
   logic access_phase;
   logic wr_lo;
   logic wr_hi;
   logic sel_wr_ok;
   assign setup_phase  = psel & ~penable;
   assign access_phase = psel & penable;
   // byte lanes holding each field
   assign wr_lo = pstrb[0];
   assign wr_hi = pstrb[1];

   always_comb
   begin
      nxt_state = state_ff;
      // writes land at the completing edge; read data is loaded at setup for the access phase
      sel_wr_ok = access_phase & pwrite & ~state_ff.lock; // [R13]
      if (psel)
      begin
         if (setup_phase)
         begin
            nxt_state.slverr = 1'b0;
            nxt_state.rdata  = '0;
         end
         unique case (paddr)
            CAPTURE_SEVEN_EIGHT_PIN_SELECT_ADDR:
            begin
               if (sel_wr_ok && wr_hi)
                  nxt_state.capture_eight_pin_field = pwdata[HIGH_FIELD_LSB +: SEL_W]; // [R5] [R12]
               if (sel_wr_ok && wr_lo)
                  nxt_state.capture_seven_pin_field = pwdata[LOW_FIELD_LSB +: SEL_W]; // [R5]
               nxt_state.rdata = pack_pair(state_ff.capture_eight_pin_field, state_ff.capture_seven_pin_field);
            end
            COMPARE_FAULT_PIN_SELECT_ADDR:
            begin
               if (sel_wr_ok && wr_lo)
                  nxt_state.compare_fault_pin_field = pwdata[LOW_FIELD_LSB +: SEL_W]; // [R6]
               nxt_state.rdata = pack_one(state_ff.compare_fault_pin_field);
            end
            PWM_ONE_FAULT_PIN_SELECT_ADDR:
            begin
               if (sel_wr_ok && wr_lo)
                  nxt_state.pwm_one_fault_pin_field = pwdata[LOW_FIELD_LSB +: SEL_W]; // [R7]
               nxt_state.rdata = pack_one(state_ff.pwm_one_fault_pin_field);
            end
            PWM_TWO_FAULT_PIN_SELECT_ADDR:
            begin
               if (sel_wr_ok && wr_lo)
                  nxt_state.pwm_two_fault_pin_field = pwdata[LOW_FIELD_LSB +: SEL_W]; // [R8]
               nxt_state.rdata = pack_one(state_ff.pwm_two_fault_pin_field);
            end
            ENCODER_ONE_PHASE_PIN_SELECT_ADDR:
            begin
               if (sel_wr_ok && wr_hi)
                  nxt_state.encoder_one_phase_b_pin_field = pwdata[HIGH_FIELD_LSB +: SEL_W]; // [R9]
               if (sel_wr_ok && wr_lo)
                  nxt_state.encoder_one_phase_a_pin_field = pwdata[LOW_FIELD_LSB +: SEL_W]; // [R9]
               nxt_state.rdata = pack_pair(state_ff.encoder_one_phase_b_pin_field,
                                           state_ff.encoder_one_phase_a_pin_field);
            end
            ENCODER_ONE_INDEX_PIN_SELECT_ADDR:
            begin
               if (sel_wr_ok && wr_lo)
                  nxt_state.encoder_one_index_pin_field = pwdata[LOW_FIELD_LSB +: SEL_W]; // [R10]
               nxt_state.rdata = pack_one(state_ff.encoder_one_index_pin_field);
            end
            ENCODER_TWO_PHASE_PIN_SELECT_ADDR:
            begin
               if (sel_wr_ok && wr_hi)
                  nxt_state.encoder_two_phase_b_pin_field = pwdata[HIGH_FIELD_LSB +: SEL_W]; // [R11]
               if (sel_wr_ok && wr_lo)
                  nxt_state.encoder_two_phase_a_pin_field = pwdata[LOW_FIELD_LSB +: SEL_W]; // [R11]
               nxt_state.rdata = pack_pair(state_ff.encoder_two_phase_b_pin_field,
                                           state_ff.encoder_two_phase_a_pin_field);
            end
            LOCK_CONTROL_ADDR:
            begin
               // lock itself stays writable so software can unlock again
               if (access_phase && pwrite && wr_lo)
                  nxt_state.lock = pwdata[LOCK_BIT];
               nxt_state.rdata[LOCK_BIT] = state_ff.lock;
            end
            default:
            begin
               nxt_state.slverr = 1'b1;
            end
         endcase
      end
      // one register stage on the pins keeps peripheral inputs glitch free
      nxt_state.routed = {route_pin(state_ff.encoder_two_phase_b_pin_field, remappable_pin_n),
                          route_pin(state_ff.encoder_two_phase_a_pin_field, remappable_pin_n),
                          route_pin(state_ff.encoder_one_index_pin_field, remappable_pin_n),
                          route_pin(state_ff.encoder_one_phase_b_pin_field, remappable_pin_n),
                          route_pin(state_ff.encoder_one_phase_a_pin_field, remappable_pin_n),
                          route_pin(state_ff.pwm_two_fault_pin_field, remappable_pin_n),
                          route_pin(state_ff.pwm_one_fault_pin_field, remappable_pin_n),
                          route_pin(state_ff.compare_fault_pin_field, remappable_pin_n),
                          route_pin(state_ff.capture_eight_pin_field, remappable_pin_n),
                          route_pin(state_ff.capture_seven_pin_field, remappable_pin_n)}; // [R14]
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_ff <= '{capture_seven_pin_field:       SEL_RESET,
                       capture_eight_pin_field:       SEL_RESET,
                       compare_fault_pin_field:       SEL_RESET,
                       pwm_one_fault_pin_field:       SEL_RESET,
                       pwm_two_fault_pin_field:       SEL_RESET,
                       encoder_one_phase_a_pin_field: SEL_RESET,
                       encoder_one_phase_b_pin_field: SEL_RESET,
                       encoder_one_index_pin_field:   SEL_RESET,
                       encoder_two_phase_a_pin_field: SEL_RESET,
                       encoder_two_phase_b_pin_field: SEL_RESET,
                       lock:                          LOCK_RESET,
                       rdata:                         '0,
                       slverr:                        1'b0,
                       routed:                        '0}; // [R3]
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   // zero wait states: every access phase completes at once
   assign pready  = 1'b1;
   assign prdata  = state_ff.rdata;
   assign pslverr = state_ff.slverr & psel & penable;
   assign pin_select_write_lock = state_ff.lock;
   assign {encoder_two_phase_b, encoder_two_phase_a, encoder_one_index, encoder_one_phase_b,
           encoder_one_phase_a, pwm_two_fault_input, pwm_one_fault_input, compare_fault_a_input,
           capture_channel_eight_input, capture_channel_seven_input} = state_ff.routed;

endmodule : input_pin_remap_select

// *** bench/remap_pin_source.sv ***
// far-side model: remappable pins driven from a requested level word
`timescale 1ns/1ns
module remap_pin_source
   import pin_remap_pkg::*;
(
   input  wire logic [pin_remap_pkg::PIN_COUNT-1:0] level_req,
   input  wire logic                                mclk,
   output logic      [pin_remap_pkg::PIN_COUNT-1:0] pin_level
);
   // pads move one edge after a request, never inside a sampling step
   always_ff @(posedge mclk)
      pin_level <= level_req;
endmodule : remap_pin_source

// *** bench/input_pin_remap_select_assertions.sv ***
// checker: apb read rules and routing of the capture seven and eight selectors
`timescale 1ns/1ns
module remap_sel_chk
   import pin_remap_pkg::*;
(
   input wire logic mclk, rst_b, psel, penable, pwrite, pslverr, pin_select_write_lock,
   input wire logic capture_channel_seven_input, capture_channel_eight_input, compare_fault_a_input,
   input wire logic [pin_remap_pkg::ADDR_W-1:0]    paddr,
   input wire logic [pin_remap_pkg::DATA_W-1:0]    pwdata, prdata,
   input wire logic [3:0]                          pstrb,
   input wire logic [pin_remap_pkg::PIN_COUNT-1:0] remappable_pin_n
);
   logic [4:0] s7_ff, s8_ff;
   // shadow of register zero, so routing can be tied to what software wrote
   wire w0 = psel && penable && pwrite && paddr == 12'h000 && !pin_select_write_lock;
   wire rd = psel && penable && !pwrite;
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
      begin
         s7_ff <= 5'h1f;
         s8_ff <= 5'h1f;
      end
      else if (w0)
      begin
         if (pstrb[0]) s7_ff <= pwdata[4:0];
         if (pstrb[1]) s8_ff <= pwdata[12:8];
      end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   AST_RESET_LOW: assert property (!$past(rst_b) |-> !capture_channel_seven_input && !compare_fault_a_input)
      else $error("input not low after reset");
   AST_UNUSED_ZERO: assert property (rd |-> prdata[31:13] == 0 && prdata[7:5] == 0)
      else $error("unused bits not zero");
   AST_SINGLE_FIELD: assert property (rd && paddr inside {12'h004, 12'h008, 12'h00c, 12'h014} |-> prdata[31:5] == 0)
      else $error("single field register upper bits set");
   AST_SEVEN_ROUTE: assert property ($past(s7_ff) < 26 |-> capture_channel_seven_input == $past(remappable_pin_n[s7_ff]))
      else $error("capture seven routes wrong pin");
   AST_SEVEN_GROUND: assert property ($past(s7_ff) > 25 |-> !capture_channel_seven_input)
      else $error("capture seven not grounded");
   AST_EIGHT_ROUTE: assert property ($past(s8_ff) < 26 |-> capture_channel_eight_input == $past(remappable_pin_n[s8_ff]))
      else $error("capture eight routes wrong pin");
   AST_EIGHT_GROUND: assert property ($past(s8_ff) > 25 |-> !capture_channel_eight_input)
      else $error("capture eight not grounded");
   AST_READBACK: assert property (rd && paddr == 12'h000 |-> prdata[12:0] == {s8_ff, 3'h0, s7_ff})
      else $error("register zero readback wrong");
endmodule : remap_sel_chk
bind input_pin_remap_select remap_sel_chk remap_sel_chk_inst (.*);

// *** bench/input_pin_remap_select_tb.sv ***
// testbench: apb register and routing checks of the input remap selectors
`timescale 1ns/1ns
module input_pin_remap_select_tb;
   import pin_remap_pkg::*;
   logic mclk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, q;
   logic [3:0] pstrb = 4'hf;
   logic [PIN_COUNT-1:0] lvl = '0, pins;
   logic [9:0] outs;
   logic lk;
   int n_errors = 0, num_checks = 0, cyc = 0;
   // field j is routed from pin 2j+1
   logic [31:0] tbl [7] = '{32'h0301, 32'h05, 32'h07, 32'h09, 32'h0d0b, 32'h0f, 32'h1311};
   always #20 mclk = ~mclk;
   remap_pin_source remap_pin_source_inst (.mclk(mclk), .level_req(lvl), .pin_level(pins));
   input_pin_remap_select input_pin_remap_select_inst (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .remappable_pin_n(pins), .capture_channel_seven_input(outs[0]),
      .capture_channel_eight_input(outs[1]), .compare_fault_a_input(outs[2]), .pwm_one_fault_input(outs[3]),
      .pwm_two_fault_input(outs[4]), .encoder_one_phase_a(outs[5]), .encoder_one_phase_b(outs[6]),
      .encoder_one_index(outs[7]), .encoder_two_phase_a(outs[8]), .encoder_two_phase_b(outs[9]),
      .pin_select_write_lock(lk));
   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : check
   // idle edge first, so back-to-back calls never drive psel twice in one step
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      int w;
      w = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1 && w < 50)
      begin
         @(posedge mclk);
         w++;
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : report_and_stop
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_errors++;
         report_and_stop();
      end
   end
   initial
   begin
      repeat (3) @(posedge mclk);
      rst_b <= 1'b1;
      for (int r = 0; r < 7; r++)
      begin
         apb(1'b0, 12'(4 * r), 32'h0);
         check("reset value", q, (tbl[r] > 32'hff) ? 32'h1f1f : 32'h1f);
         apb(1'b1, 12'(4 * r), 32'hffffe0e0 | tbl[r]);
         apb(1'b0, 12'(4 * r), 32'h0);
         check("readback", q, tbl[r]);
         check("mapped no error", 32'(err), 32'h0);
      end
      for (int j = 0; j < 10; j++)
      begin
         lvl <= 26'(1) << (2 * j + 1);
         repeat (3) @(posedge mclk);
         check("field route", 32'(outs), 32'(1) << j);
      end
      for (int k = 0; k < 32; k++)
      begin
         apb(1'b1, 12'h000, 32'h1f00 | k);
         lvl <= (k < 26) ? 26'(1) << k : '1;
         repeat (3) @(posedge mclk);
         check("selected pin high", 32'(outs[0]), 32'(k < 26));
         lvl <= ~(26'(1) << k);
         repeat (3) @(posedge mclk);
         check("selected pin low or grounded", 32'(outs[0]), 32'h0);
      end
      apb(1'b1, LOCK_CONTROL_ADDR, 32'h1);
      @(posedge mclk);
      check("lock flag set", 32'(lk), 32'h1);
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b0, 12'h000, 32'h0);
      check("locked write", q, 32'h1f1f);
      apb(1'b1, LOCK_CONTROL_ADDR, 32'h0);
      @(posedge mclk);
      check("lock flag clear", 32'(lk), 32'h0);
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b0, 12'h000, 32'h0);
      check("unlocked write", q, 32'h0);
      apb(1'b0, 12'h020, 32'h0);
      check("unmapped error", 32'(err), 32'h1);
      rst_b <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      apb(1'b0, 12'h000, 32'h0);
      check("second reset value", q, 32'h1f1f);
      report_and_stop();
   end
endmodule : input_pin_remap_select_tb
